// File: bcs_top.sv
/*
 Synchronous burst cache memory: registered inputs, burst counter,
 late-decision write and registered output enable on the data pins.
 Assumes a bus master samples and drives all pins on clk_sys falling edges.
*/
`default_nettype none

module bcs_top
	import bcs_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// Control pins
	input  wire logic              address_strobe_n,
	input  wire logic              chip_select_n,
	input  wire logic              write_enable_n,
	input  wire logic              output_enable_n,
	// Address pins
	input  wire logic [ADDR_W-1:0] addr_in,
	// Data pins, split into three signals
	input  wire logic [DATA_W-1:0] data_io_in,
	output logic      [DATA_W-1:0] data_io_out,
	output logic                   data_io_oe_n
);
	logic              rst_meta;
	logic              rst_n;
	logic              strobe_prev_n;
	logic              load;
	logic              advance;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_en;
	logic [DATA_W-1:0] rd_data;
	logic              next_oe_n;

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Strobe is only honoured on its falling sample, a held low does not reload
	assign load    = !address_strobe_n && strobe_prev_n; // R5 R7
	assign advance = !chip_select_n; // R8 R9

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_prev_n <= 1'b1;
		end else begin
			strobe_prev_n <= address_strobe_n;
		end
	end

	bcs_burst_ctr u_ctr (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.load       (load),
		.advance    (advance),
		.start_addr (addr_in),
		.cur_addr   (cur_addr)
	);

	// Data, address and enable captured one edge after the address is loaded
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_addr <= '0;
			wr_data <= '0;
			wr_en   <= 1'b0;
		end else begin
			wr_addr <= cur_addr; // R10 R14
			wr_data <= data_io_in; // R11
			wr_en   <= !write_enable_n && !chip_select_n; // R13
		end
	end

	// Array read follows the counter one cycle behind
	bcs_mem u_mem (
		.clk_sys (clk_sys),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (cur_addr), // R1 R3
		.rd_data (rd_data)
	);

	// Enable is sampled here since outputs must come from flops; a true
	// asynchronous enable lives in the pad, one cycle is the trade-off
	assign next_oe_n = output_enable_n || !write_enable_n; // R16

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_io_oe_n <= 1'b1;
			data_io_out  <= '0;
		end else begin
			data_io_oe_n <= next_oe_n; // R16
			data_io_out  <= rd_data;
		end
	end

	// A load edge must set the counter to the pins, not step it
	load_no_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		load |=> cur_addr == $past(addr_in)) // R19
		else $error("Burst start address not loaded");

	hold_when_cs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!load && chip_select_n) |=> $stable(cur_addr)) // R9
		else $error("Counter moved with chip select high");

	sequence s_start;
		load ##1 !chip_select_n && !load;
	endsequence
	order_bit0_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_start |=> cur_addr == ($past(cur_addr) ^ {{(ADDR_W-2){1'b0}}, BEAT_MASK0})) // R4
		else $error("Second beat not low bit flipped");

	// Without a load only the two burst bits may move; the pins never reach the counter
	ignore_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!load |=> cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2])) // R7
		else $error("Address pins used without strobe edge");

	wrap_four_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(load ##1 (!load && !chip_select_n)[*4]) |=> cur_addr == $past(cur_addr, 4)) // R6
		else $error("Burst did not wrap after four beats");

	write_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(write_enable_n || chip_select_n) |=> !wr_en) // R13
		else $error("Write without both enables");

	write_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		load |=> ##1 wr_addr == $past(addr_in, 2)) // R10
		else $error("Write address not the start address");

	write_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> wr_data == $past(data_io_in)) // R11
		else $error("Write data not captured");

	read_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!output_enable_n && write_enable_n) |=> !data_io_oe_n) // R16
		else $error("Read not driven on data pins");

	restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(address_strobe_n ##1 !address_strobe_n) |=> cur_addr == $past(addr_in)) // R5
		else $error("New strobe did not restart burst");
endmodule : bcs_top

`default_nettype wire

// File: bcs_pkg.sv
/*
 Package of constants for the burst cache static memory block.
 Assumes one system clock at 10 MHz and an active-low asynchronous reset.
*/
// Overview of operation
// R1: 32K by 9 array behind registered inputs
// R2: Strobe low loads start address into counter
// R3: Start accessed next cycle, three more beats
// R4: Order start, bit0, bit1, both bits flipped
// R5: New strobe after idle restarts burst
// R6: Counter wraps and keeps counting
// R7: Address pins ignored unless strobe newly low
// R8: Chip select low enables counter advance
// R9: Chip select high holds counter state
// R10: Write address captured at strobe edge
// R11: Data and write enable captured next edge
// R12: Registered write performed in that cycle
// R13: Write needs chip select and enable low
// R14: Burst write follows burst address order
// R15: Master releases output enable before write
// R16: Output enable drives pins asynchronously; here it is sampled on clk_sys and acts one cycle later
// R17: Copy-back may read then write burst
// R18: Master never asserts all three together
// R19: Load edge takes value without advancing
`default_nettype none

package bcs_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 9;
	localparam int DEPTH  = 32768;
	localparam logic [1:0] BEAT_STEP  = 2'h1;
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_MASK0 = 2'h1; // Low bit flip
	localparam logic [1:0] BEAT_MASK1 = 2'h2; // Second bit flip
	localparam logic [1:0] BEAT_MASK2 = 2'h3; // Both bits flipped
endpackage : bcs_pkg

`default_nettype wire

// File: bcs_mem.sv
/*
 Memory array of 32K words by 9 bits with registered read data.
 Assumes the caller presents one read and at most one write per cycle.
*/
`default_nettype none

module bcs_mem
	import bcs_pkg::*;
(
	// Clock
	input  wire logic              clk_sys,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// Read port
	input  wire logic [ADDR_W-1:0] rd_addr,
	output var  logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] array [DEPTH];

	// Write lands in the cycle after capture, standing in for the low clock phase
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			array[wr_addr] <= wr_data; // R12
		end
		rd_data <= array[rd_addr];
	end
endmodule : bcs_mem

`default_nettype wire

// File: bcs_burst_ctr.sv
/*
 Four-beat burst address counter in processor refill order.
 Assumes strobe and chip select are synchronous, already sampled.
*/
`default_nettype none

module bcs_burst_ctr
	import bcs_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Control
	input  wire logic              load,
	input  wire logic              advance,
	input  wire logic [ADDR_W-1:0] start_addr,
	// Current burst address
	output logic      [ADDR_W-1:0] cur_addr
);
	logic [ADDR_W-1:0] base;
	logic [1:0]        beat;
	logic [1:0]        flip;
	logic [1:0]        next_beat;

	// Beat count picks the flip mask of the refill order; two bits wrap on their own
	assign next_beat = beat + BEAT_STEP; // R6
	assign flip = (beat == BEAT_FIRST) ? BEAT_FIRST :
		(beat == BEAT_MASK0) ? BEAT_MASK0 :
		(beat == BEAT_MASK1) ? BEAT_MASK1 : BEAT_MASK2; // R4
	assign cur_addr = {base[ADDR_W-1:2], base[1:0] ^ flip}; // R14

	// Load wins over advance, so a load edge never also steps
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			base <= '0;
			beat <= BEAT_FIRST;
		end else if (load) begin
			base <= start_addr; // R2 R19
			beat <= BEAT_FIRST;
		end else if (advance) begin
			beat <= next_beat; // R8
		end
	end
endmodule : bcs_burst_ctr

`default_nettype wire

// File: bcs_master.sv
/*
 Bus master model that drives the burst memory pins.
 Assumes the memory samples every pin on rising clk_sys edges.
*/
`default_nettype none

module bcs_master
	import bcs_pkg::*;
(
	// Clock
	input  wire logic              clk_sys,
	// Pins toward the memory
	output logic                   ads_n,
	output logic                   cs_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] din
);
	timeunit 1ns;
	timeprecision 1ns;
	integer seed = 32'h27FF;

	// Idle pins, data changes every cycle so stale values never match
	initial begin
		{ads_n, cs_n, we_n, oe_n, addr} = {4'hF, 15'h0000};
		forever @(negedge clk_sys) din = $random(seed);
	end

	// Load edge, then n beats with chip select high at beat st
	task automatic burst(input logic wr, input logic [ADDR_W-1:0] a,
		input int n, input int st, input logic hold);
		@(negedge clk_sys);
		ads_n = 1'b0;
		addr = a;
		cs_n = 1'b0;
		we_n = 1'b1;
		oe_n = wr;
		for (int k = 0; k < n; k++) begin
			@(negedge clk_sys);
			ads_n = !(hold && k == 0);
			addr = ~a;
			cs_n = (k == st);
			we_n = !wr;
		end
	endtask : burst
endmodule : bcs_master

`default_nettype wire

// File: test_burst_cache_sram.sv
/*
 Self-checking bench for the burst cache memory with a reference model.
 Assumes bcs_top and the bcs_master partner model.
*/
`default_nettype none

module test_burst_cache_sram;
	import bcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic ads_n, cs_n, we_n, oe_n, oe_o, ads_q, ld, v1, v2;
	logic loaded = 1'b0;
	logic oe_exp = 1'b1;
	logic [ADDR_W-1:0] addr, cnt, base, a;
	logic [DATA_W-1:0] din, dout, rd1, rd2;
	logic [DATA_W-1:0] rm [int];
	int num_errors = 0;
	int num_checks = 0;

	bcs_top bcs_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .address_strobe_n(ads_n),
		.chip_select_n(cs_n), .write_enable_n(we_n), .output_enable_n(oe_n),
		.addr_in(addr), .data_io_in(din), .data_io_out(dout), .data_io_oe_n(oe_o));
	bcs_master bcs_master_inst (.clk_sys(clk_sys), .ads_n(ads_n), .cs_n(cs_n),
		.we_n(we_n), .oe_n(oe_n), .addr(addr), .din(din));

	initial forever #50 clk_sys = ~clk_sys;

	// Next burst address: low bits step through the flip masks and wrap
	function automatic logic [ADDR_W-1:0] nxt(input logic [ADDR_W-1:0] c, b);
		logic [1:0] m;
		m = (c[1:0] ^ b[1:0]) + 2'h1;
		return {c[ADDR_W-1:2], b[1:0] ^ m};
	endfunction : nxt

	task automatic chk(input logic [DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Reference: read before write so a same-edge write never leaks in
	always @(posedge clk_sys) begin
		ld = !ads_n && ads_q;
		v1 <= loaded && we_n && rm.exists(cnt);
		rd1 <= loaded && rm.exists(cnt) ? rm[cnt] : '0;
		v2 <= v1;
		rd2 <= rd1;
		if (loaded && !ld && !we_n && !cs_n) rm[cnt] = din;
		if (ld) begin
			cnt <= addr;
			base <= addr;
			loaded <= 1'b1;
		end else if (!cs_n) cnt <= nxt(cnt, base);
		ads_q <= ads_n;
		oe_exp <= !(!oe_n && we_n);
	end

	// Compare settled outputs mid-cycle
	always @(negedge clk_sys) if (reset_n) begin
		chk(DATA_W'(oe_o), DATA_W'(oe_exp));
		if (v2) chk(dout, rd2);
	end

	initial begin
		repeat (20) @(negedge clk_sys);
		chk(DATA_W'(oe_o), 9'h001);
		chk(dout, 9'h000);
		reset_n = 1'b1;
		repeat (5) @(negedge clk_sys);
		for (int i = 0; i < 12; i++) begin
			a = i < 2 ? {ADDR_W{i[0]}} : ADDR_W'($random(bcs_master_inst.seed));
			bcs_master_inst.burst(1'b1, a, 4 + i % 2, i % 5, 1'b0);
			bcs_master_inst.burst(1'b0, a, 2 + i % 5, i % 3, i[0]);
			$display("test %0d done, checks %0d", i, num_checks);
		end
		repeat (4) @(negedge clk_sys);
		wrap_up();
	end

	// Watchdog well beyond the expected 150 or so cycles
	initial begin
		#300000;
		num_errors++;
		wrap_up();
	end
endmodule : test_burst_cache_sram

`default_nettype wire
